// ===== hdl/sah_pkg.sv
// Functional notes
// - busy output returns high when conversion finishes, usable as interrupt.
// - wide variant gives 16-bit result; byte variant gives 8-bit bus.
// - with select and read held low, data valid at busy rising edge.
// - conversion plus acquisition takes 6 us; one start per 6 us at most.
// - every result is delivered as two's complement code.
// - after start rising edge busy falls; first phase lasts 3.35 us (here rounded down to 83 cycles, 3.32 us).
package sah_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam real PHASE1_US = 3.35;
   localparam real CYCLE_US = 6.0;
   localparam real CONV_US = 5.3;
   // longest times round down, never below one cycle
   localparam int unsigned PHASE1_CYC_R = int'($floor(PHASE1_US * CLK_HZ / 1.0e6));
   localparam int unsigned CONV_CYC_R = int'($floor(CONV_US * CLK_HZ / 1.0e6));
   localparam int unsigned CYCLE_CYC_R = int'($floor(CYCLE_US * CLK_HZ / 1.0e6));
   localparam int unsigned PHASE1_CYC = (PHASE1_CYC_R < 1) ? 1 : PHASE1_CYC_R;
   localparam int unsigned CONV_CYC = (CONV_CYC_R < 1) ? 1 : CONV_CYC_R;
   localparam int unsigned CYCLE_CYC = (CYCLE_CYC_R < 1) ? 1 : CYCLE_CYC_R;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam logic [15:0] MIDSCALE_OFS = 16'h8000;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

   typedef enum logic [1:0] {
      SAH_IDLE = 2'b00,
      SAH_PH1 = 2'b01,
      SAH_PH2 = 2'b11,
      SAH_ACQ = 2'b10
   } sah_state_t;

   typedef struct packed {
      logic chipSelN;
      logic readN;
      logic byteHighSel;
   } sah_rd_t;
endpackage

// ===== hdl/sah_read_port.sv
// drives the data bus from the held result; combinational enable, data from flops
module sah_read_port (
   // clock and reset
   input wire logic sysClk,
   input wire logic rstN,
   // control
   input wire sah_pkg::sah_rd_t rdCtl,
   input wire logic byteMode,
   input wire logic [15:0] result,
   // bus
   output logic [15:0] dataOut,
   output logic dataOeN
);
   logic [15:0] dataD;
   logic [15:0] dataQ;

   always_comb begin
      dataD = result;
      if (byteMode) begin
         // high byte or low byte chosen per read
         dataD = {8'h00, rdCtl.byteHighSel ? result[15:8] : result[7:0]};
      end
   end

   always_ff @(posedge sysClk) begin
      if (!rstN) begin
         dataQ <= sah_pkg::RESULT_RST;
      end else begin
         dataQ <= dataD;
      end
   end

   assign dataOut = dataQ;
   // low while driving the bus
   assign dataOeN = rdCtl.chipSelN | rdCtl.readN;
endmodule // sah_read_port

// ===== hdl/sah_adc_handshake.sv
// converter timing core: start edge, two phases, busy, result latch
module sah_adc_handshake (
   // clock and reset
   input wire logic sysClk,
   input wire logic rstN,
   // start inputs
   input wire logic conversionStartN,
   // read inputs
   input wire sah_pkg::sah_rd_t rdCtl,
   input wire logic byteMode,
   // sampled analog code, offset binary from the quantiser
   input wire logic [15:0] sampleCode,
   // outputs
   output logic busyN,
   output logic [15:0] dataOut,
   output logic dataOeN,
   output logic startRefused
);
   // start edge detector
   logic startPrevD;
   logic startPrevQ;
   logic startRise;

   // sequencer
   sah_pkg::sah_state_t stateD;
   sah_pkg::sah_state_t stateQ;
   logic [sah_pkg::CNT_W-1:0] cntD;
   logic [sah_pkg::CNT_W-1:0] cntQ;
   logic phase1Done;
   logic convDone;
   logic cycleDone;

   // held sample and result
   logic [15:0] heldD;
   logic [15:0] heldQ;
   logic [15:0] resultD;
   logic [15:0] resultQ;

   // status
   logic busyD;
   logic busyQ;
   logic refuseD;
   logic refuseQ;

   // true on the last cycle of a span counted from the start edge
   function automatic logic cntAt(
      input logic [7:0] cnt,
      input int unsigned cyc
   );
      logic [7:0] last;
      last = 8'(cyc - 32'd1);
      return cnt == last;
   endfunction

   function automatic logic isIdle(input sah_pkg::sah_state_t st);
      return st == sah_pkg::SAH_IDLE;
   endfunction

   // ---- start edge detector group ----

   always_comb begin
      startPrevD = conversionStartN;
   end

   always_ff @(posedge sysClk) begin
      if (!rstN) begin
         // idle level of the pin, so no false edge follows reset
         startPrevQ <= 1'b1;
      end else begin
         startPrevQ <= startPrevD;
      end
   end

   // conversion begins on the rising edge of the start pulse
   assign startRise = conversionStartN & ~startPrevQ;

   // ---- sequencer group ----

   assign phase1Done = cntAt(cntQ, sah_pkg::PHASE1_CYC);
   assign convDone = cntAt(cntQ, sah_pkg::CONV_CYC);
   assign cycleDone = cntAt(cntQ, sah_pkg::CYCLE_CYC);

   always_comb begin
      stateD = stateQ;
      cntD = cntQ + 8'h01;
      case (stateQ)
         sah_pkg::SAH_IDLE: begin
            cntD = sah_pkg::CNT_RST;
            if (startRise) begin
               stateD = sah_pkg::SAH_PH1;
            end
         end
         sah_pkg::SAH_PH1: begin
            if (phase1Done) begin
               stateD = sah_pkg::SAH_PH2;
            end
         end
         sah_pkg::SAH_PH2: begin
            if (convDone) begin
               stateD = sah_pkg::SAH_ACQ;
            end
         end
         sah_pkg::SAH_ACQ: begin
            // acquisition tail keeps the 6 us throughput limit
            if (cycleDone) begin
               stateD = sah_pkg::SAH_IDLE;
            end
         end
         default: begin
            stateD = sah_pkg::SAH_IDLE;
            cntD = sah_pkg::CNT_RST;
         end
      endcase
   end

   always_ff @(posedge sysClk) begin
      if (!rstN) begin
         stateQ <= sah_pkg::SAH_IDLE;
         cntQ <= sah_pkg::CNT_RST;
      end else begin
         stateQ <= stateD;
         cntQ <= cntD;
      end
   end

   // ---- held sample and result group ----

   always_comb begin
      heldD = heldQ;
      resultD = resultQ;
      case (stateQ)
         sah_pkg::SAH_IDLE: begin
            if (startRise) begin
               heldD = sampleCode;
            end
         end
         sah_pkg::SAH_PH2: begin
            if (convDone) begin
               // offset to two's complement by flipping the sign bit
               resultD = heldQ ^ sah_pkg::MIDSCALE_OFS;
            end
         end
         default: begin
            heldD = heldQ;
         end
      endcase
   end

   always_ff @(posedge sysClk) begin
      if (!rstN) begin
         heldQ <= sah_pkg::RESULT_RST;
         resultQ <= sah_pkg::RESULT_RST;
      end else begin
         heldQ <= heldD;
         resultQ <= resultD;
      end
   end

   // ---- status group ----

   always_comb begin
      busyD = busyQ;
      refuseD = 1'b0;
      case (stateQ)
         sah_pkg::SAH_IDLE: begin
            if (startRise) begin
               busyD = 1'b1;
            end
         end
         sah_pkg::SAH_PH2: begin
            if (convDone) begin
               busyD = 1'b0;
            end
         end
         sah_pkg::SAH_PH1: begin
            busyD = 1'b1;
         end
         sah_pkg::SAH_ACQ: begin
            busyD = 1'b0;
         end
         default: begin
            busyD = 1'b0;
         end
      endcase
      // a start during busy or acquisition is ignored, only flagged
      if (startRise && !isIdle(stateQ)) begin
         refuseD = 1'b1;
      end
   end

   always_ff @(posedge sysClk) begin
      if (!rstN) begin
         busyQ <= 1'b0;
         refuseQ <= 1'b0;
      end else begin
         busyQ <= busyD;
         refuseQ <= refuseD;
      end
   end

   assign busyN = ~busyQ;
   assign startRefused = refuseQ;

   // ---- read port ----

   // the port registers the next result, so with select and read held
   // low the new word already stands when busy rises
   sah_read_port i_sah_read_port (
      .sysClk(sysClk),
      .rstN(rstN),
      .rdCtl(rdCtl),
      .byteMode(byteMode),
      .result(resultD),
      .dataOut(dataOut),
      .dataOeN(dataOeN)
   );

   // limitation: byte reads see the chosen byte one cycle after byteHighSel
   // moves, as the bus output is registered
endmodule // sah_adc_handshake

// ===== verif/sah_host_model.sv
module sah_host_model (
   // clock
   input wire logic sysClk,
   // converter controls
   output logic conversionStartN,
   output sah_pkg::sah_rd_t rdCtl
);
   timeunit 1ns;
   timeprecision 1ns;
   initial conversionStartN = 1'b1;
   initial rdCtl = 3'b110;
   task automatic st();
      @(negedge sysClk) conversionStartN = 1'b0;
      @(negedge sysClk) conversionStartN = 1'b1;
   endtask
   // select and read move together
   task automatic sel(input logic on, input logic hi);
      @(negedge sysClk) rdCtl = {!on, !on, hi};
   endtask
endmodule // sah_host_model

// ===== verif/sah_adc_handshake_assertions.sv
module sah_adc_handshake_assertions (
   // clock and reset
   input wire logic sysClk,
   input wire logic rstN,
   // watched
   input wire logic conversionStartN,
   input wire sah_pkg::sah_rd_t rdCtl,
   input wire logic byteMode,
   input wire logic [15:0] sampleCode,
   input wire logic busyN,
   input wire logic [15:0] dataOut,
   input wire logic dataOeN,
   input wire logic startRefused
);
   logic [15:0] capQ;
   logic gotQ;
   wire logic [15:0] r = capQ ^ 16'h8000;
   wire logic sel = !rdCtl.chipSelN && !rdCtl.readN;
   default clocking @(posedge sysClk); endclocking
   default disable iff (!rstN);
   // code was taken one edge before busy fell
   always_ff @(posedge sysClk) begin
      gotQ <= rstN && (gotQ || $fell(busyN));
      if ($fell(busyN)) capQ <= $past(sampleCode);
   end
   sequence s_take; $rose(conversionStartN); endsequence
   sequence s_conv; !busyN throughout ##131 1'b1; endsequence
   property p_st; s_take |=> !busyN || startRefused; endproperty
   property p_busy; $fell(busyN) |-> s_conv ##1 busyN; endproperty
   property p_ref; $fell(busyN) ##[0:147] s_take |=> startRefused; endproperty
   property p_pul;
      startRefused |-> $past(conversionStartN) && !$past(conversionStartN, 2);
   endproperty
   property p_oe; dataOeN == !sel; endproperty
   property p_sa;
      gotQ && $rose(busyN) && $past(sel) && !$past(byteMode) |-> dataOut == r;
   endproperty
   property p_hi; $past(byteMode) |-> dataOut[15:8] == 8'h00; endproperty
   property p_dat;
      gotQ && busyN && $past(busyN) && $past(sel) |-> dataOut == ($past(
         byteMode) ? {8'h00, $past(rdCtl.byteHighSel) ? r[15:8] : r[7:0]} : r);
   endproperty
   a_st: assert property (p_st) else $error("start");
   a_busy: assert property (p_busy) else $error("busy");
   a_ref: assert property (p_ref) else $error("ref");
   a_pul: assert property (p_pul) else $error("pulse");
   a_oe: assert property (p_oe) else $error("oe");
   a_sa: assert property (p_sa) else $error("standalone");
   a_hi: assert property (p_hi) else $error("hi");
   a_dat: assert property (p_dat) else $error("data");
endmodule // sah_adc_handshake_assertions
bind sah_adc_handshake sah_adc_handshake_assertions i_chk (.*);

// ===== verif/sah_adc_handshake_tb.sv
module sah_adc_handshake_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sysClk, rstN, conversionStartN, byteMode, busyN, dataOeN;
   logic startRefused, look;
   logic [15:0] sampleCode, dataOut, ex;
   sah_pkg::sah_rd_t rdCtl;
   logic [15:0] q[$];
   int errCount, nTests;
   sah_adc_handshake i_sah_adc_handshake (.*);
   sah_host_model i_sah_host_model (.*);
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic stopTest();
      if (errCount == 0 && nTests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] x, logic [15:0] s);
      nTests++;
      if (s !== x) begin
         errCount++;
         $display("CHECK FAILED %s exp %h got %h", n, x, s);
      end
   endtask
   task automatic want(logic [15:0] v);
      q.push_back(v);
      look <= 1'b1;
      @(negedge sysClk) look <= 1'b0;
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge sysClk);
   endtask
   always @(negedge sysClk)
      if (look) chk("data", q.pop_front(), dataOut);
   initial begin
      sysClk = 1'b0;
      forever #20 sysClk = ~sysClk;
   end
   initial begin
      {rstN, byteMode, look} = 3'b000;
      sampleCode = 16'h0038;
      tick(10);
      rstN = 1'b1;
      for (int k = 0; k < 4; k++) begin
         sampleCode = lfsr(sampleCode);
         ex = sampleCode ^ 16'h8000;
         byteMode = k[0];
         i_sah_host_model.sel(!k[0], 1'b0);
         i_sah_host_model.st();
         tick(2);
         chk("busy", 16'h0, {15'h0, busyN});
         if (k == 3) begin
            tick(20);
            i_sah_host_model.st();
            tick(1);
            chk("refused", 16'h1, {15'h0, startRefused});
         end
         if (k[0]) begin
            tick(163);
            i_sah_host_model.sel(1'b1, 1'b1);
            want({8'h00, ex[15:8]});
            i_sah_host_model.sel(1'b1, 1'b0);
            want({8'h00, ex[7:0]});
         end else begin
            for (int n = 0; n < 300 && busyN !== 1'b1; n++) tick(1);
            chk("busy", 16'h1, {15'h0, busyN});
            if (busyN !== 1'b1) stopTest();
            want(ex);
            tick(20);
         end
      end
      stopTest();
   end
endmodule // sah_adc_handshake_tb
